// ---- core/lsfw_byte_if.sv ----
`timescale 1ns/1ps
interface lsfw_byte_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// ---- core/lsfw_cfg.svh ----
`ifndef LSFW_CFG_SVH
`define LSFW_CFG_SVH

// Register offsets on the internal serial-bus register port
`define LSFW_ADDR_CFG0   8'hF9
`define LSFW_ADDR_CFG1   8'hFA
`define LSFW_ADDR_THR    8'hFC
`define LSFW_ADDR_STAT0  8'hFD
`define LSFW_ADDR_STAT1  8'hFE
`define LSFW_ADDR_DATA   8'hFF

// Field positions of the per-modulator format register
`define LSFW_BIT_LIGHT_EN 7
`define LSFW_BIT_COMP_EN  5
`define LSFW_BIT_DIFF_EN  4
`define LSFW_CFG_WMASK    8'hBF

// Reset values
`define LSFW_CFG_RST      8'h8F
`define LSFW_THR_RST      8'h7F

// Sizes
`define LSFW_FIFO_BYTES   512
`define LSFW_RAW_BITS     16

`endif

// ---- core/lsfw_packer.sv ----
`timescale 1ns/1ps
`include "lsfw_cfg.svh"
module lsfw_packer #(
  parameter int SAMPLE_W = 16
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  lsfw_pkg::lsfw_modcfg_t    cfg,
  input  wire logic                 flickerValid,
  input  wire logic [SAMPLE_W-1:0]  flickerSample,
  input  wire logic                 lightValid,
  input  wire logic [SAMPLE_W-1:0]  lightResult,
  input  wire logic                 flush,
  output logic                      lightTaken,
  lsfw_byte_if.source               byteOut
);

  logic [31:0]         acc;
  logic [5:0]          fill;
  logic [SAMPLE_W-1:0] prev;
  logic                room;
  logic [4:0]          width;
  logic [5:0]          alignFill;
  logic [SAMPLE_W-1:0] value;

  function automatic logic [SAMPLE_W-1:0] keepLow(
    input logic [SAMPLE_W-1:0] v,
    input logic [4:0]          n);
    logic [SAMPLE_W-1:0] m;
    m = '1;
    keepLow = v & (m >> (5'(SAMPLE_W) - n));
  endfunction

  // Accumulator never holds a full byte when new data enters
  assign room         = fill < 6'd8;
  assign width        = {1'b0, cfg.bits} + 5'd1;
  assign alignFill    = (fill == 6'd0) ? 6'd0 : 6'd8;
  assign byteOut.valid = !room;
  assign byteOut.data  = acc[7:0];
  assign lightTaken    = room && lightValid;

  // RULE5 delta coding
  always_comb begin
    if (cfg.compEn && cfg.diffEn) begin
      value = keepLow(flickerSample - prev, width);
    end else begin
      // RULE7 keep low bits
      value = keepLow(flickerSample, width);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc  <= 32'h0000_0000;
      fill <= 6'h00;
    end else if (byteOut.valid && byteOut.ready) begin
      acc  <= acc >> 8;
      fill <= fill - 6'd8;
    end else if (room) begin
      if (lightValid) begin
        acc  <= acc | (32'(lightResult) << alignFill);
        fill <= alignFill + 6'd16;
      end else if (flickerValid && cfg.compEn) begin
        // RULE4 bit-packed stream
        acc  <= acc | (32'(value) << fill);
        fill <= fill + 6'(width);
      end else if (flickerValid) begin
        // RULE10 fixed two-byte slot
        acc  <= acc | (32'(value) << alignFill);
        fill <= alignFill + 6'd16;
      end else if (flush && fill != 6'd0) begin
        fill <= 6'd8;
      end
    end
  end

  // Delta reference restarts with every measurement
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev <= '0;
    end else if (flush) begin
      prev <= '0;
    end else if (room && !lightValid && flickerValid) begin
      prev <= flickerSample;
    end
  end

  sequence compTake_s;
    room && !lightValid && flickerValid && cfg.compEn;
  endsequence

  // RULE4 packed growth
  comp_fill_a: assert property (@(posedge clk_sys) // RULE4
    disable iff (!rst_n)
    compTake_s |=> fill == $past(fill) + 6'($past(width)))
    else $error("packed fill grew by wrong amount");

  // RULE10 slot growth
  raw_fill_a: assert property (@(posedge clk_sys) // RULE10
    disable iff (!rst_n)
    room && !lightValid && flickerValid && !cfg.compEn
    |=> fill == $past(alignFill) + 6'd16)
    else $error("uncompressed sample not two bytes");

  // RULE7 width masking
  width_mask_a: assert property (@(posedge clk_sys) // RULE7
    disable iff (!rst_n)
    compTake_s |-> (32'(value) >> width) == 32'h0000_0000)
    else $error("sample bits above width kept");

endmodule

// ---- core/lsfw_pkg.sv ----
package lsfw_pkg;

  // Mirrors the bit layout of a per-modulator format register
  typedef struct packed {
    logic       lightEn;
    logic       rsvd;
    logic       compEn;
    logic       diffEn;
    logic [3:0] bits;
  } lsfw_modcfg_t;

endpackage

// ---- core/lsfw_top.sv ----
`timescale 1ns/1ps
`include "lsfw_cfg.svh"
// Contract
// RULE1 - Mod 0 light result stored if no flicker or light >= flicker count.
// RULE2 - With light count below flicker count, storing needs the after flag.
// RULE3 - Modulator 1 follows the same light rules under its own bit 7.
// RULE4 - Register bit 5 enables bit-packed compression of flicker samples.
// RULE5 - Bit 4 stores the difference to the prior sample of that modulator.
// RULE6 - The host sets difference mode only together with compression.
// RULE7 - Width field N stores bits 0 to N, N+1 bits, of each flicker sample.
// RULE8 - The shared FIFO holds 512 bytes and its level runs from 0 to 512.
// RULE9 - The FIFO interrupt is high while the level exceeds the threshold; the code compares the level against twice the threshold register value.
// RULE10 - Uncompressed samples keep N+1 bits in two bytes, no difference.
module lsfw_top #(
  parameter int CNT_W    = 16,
  parameter int SAMPLE_W = `LSFW_RAW_BITS,
  parameter int DEPTH    = `LSFW_FIFO_BYTES
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic [7:0]               regAddr,
  input  wire logic                     regWrEn,
  input  wire logic [7:0]               regWrData,
  input  wire logic                     regRdEn,
  output logic      [7:0]               regRdData,
  input  wire logic                     flickerStepEn,
  input  wire logic                     lightAfterFlicker,
  input  wire logic [CNT_W-1:0]         lightSampleCount,
  input  wire logic [CNT_W-1:0]         flickerSampleCount,
  input  wire logic [1:0]               lightValid,
  input  wire logic [1:0][SAMPLE_W-1:0] lightResult,
  input  wire logic [1:0]               flickerValid,
  input  wire logic [1:0][SAMPLE_W-1:0] flickerSample,
  input  wire logic                     measEnd,
  output logic      [9:0]               fifoFillLevel,
  output logic                          fifoIrq
);

  localparam int AW = $clog2(DEPTH);

  lsfw_pkg::lsfw_modcfg_t    modCfg [2];
  logic [7:0]                fifoFillThreshold;
  logic [1:0]                lightPend;
  logic [1:0][SAMPLE_W-1:0]  lightBuf;
  logic [1:0]                lightTaken;
  logic [1:0]                lightOk;
  logic [7:0]                mem [DEPTH];
  logic [AW-1:0]             wrPtr;
  logic [AW-1:0]             rdPtr;
  logic                      lastSel;
  logic                      sel;
  logic                      full;
  logic                      push;
  logic                      popOk;
  logic [7:0]                pushData;
  logic [9:0]                next_level;
  logic [9:0]                thrLevel;
  logic [7:0]                next_thr;

  lsfw_byte_if byteBus [2] ();

  // RULE1 light store gate
  // RULE2 after-flicker exception
  // RULE3 per-modulator enable
  always_comb begin
    for (int m = 0; m < 2; m++) begin
      lightOk[m] = modCfg[m].lightEn &&
                   (!flickerStepEn ||
                    lightSampleCount >= flickerSampleCount ||
                    lightAfterFlicker);
    end
  end

  // A new result wins over the hand-off of an older one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lightPend <= 2'b00;
      lightBuf  <= '0;
    end else begin
      for (int m = 0; m < 2; m++) begin
        if (lightValid[m] && lightOk[m]) begin
          lightPend[m] <= 1'b1;
          lightBuf[m]  <= lightResult[m];
        end else if (lightTaken[m]) begin
          lightPend[m] <= 1'b0;
        end
      end
    end
  end

  // Flicker samples arriving while a packer drains a byte are lost;
  // the sample clock must leave the packer a cycle per byte.
  for (genvar g = 0; g < 2; g++) begin : gPack
    lsfw_packer #(
      .SAMPLE_W (SAMPLE_W)
    ) uPacker (
      .clk_sys       (clk_sys),
      .rst_n         (rst_n),
      .cfg           (modCfg[g]),
      .flickerValid  (flickerValid[g]),
      .flickerSample (flickerSample[g]),
      .lightValid    (lightPend[g]),
      .lightResult   (lightBuf[g]),
      .flush         (measEnd),
      .lightTaken    (lightTaken[g]),
      .byteOut       (byteBus[g])
    );
  end

  // Round robin between the two modulators
  assign sel = byteBus[0].valid && (!byteBus[1].valid || lastSel);
  assign byteBus[0].ready = !full && sel;
  assign byteBus[1].ready = !full && !sel;
  assign pushData = sel ? byteBus[0].data : byteBus[1].data;
  assign push = !full && (byteBus[0].valid || byteBus[1].valid);
  // RULE8 capacity bound
  assign full = fifoFillLevel == 10'(DEPTH);
  assign popOk = regRdEn && regAddr == `LSFW_ADDR_DATA &&
                 fifoFillLevel != 10'h000;
  assign next_level = fifoFillLevel + {9'h000, push} - {9'h000, popOk};
  assign thrLevel = {1'b0, fifoFillThreshold, 1'b0};
  // Irq tracks a threshold write in the same cycle as the level
  assign next_thr = (regWrEn && regAddr == `LSFW_ADDR_THR) ? regWrData :
                    fifoFillThreshold;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lastSel <= 1'b0;
    end else if (push) begin
      lastSel <= !sel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr] <= pushData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr         <= '0;
      rdPtr         <= '0;
      fifoFillLevel <= 10'h000;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (popOk) begin
        rdPtr <= rdPtr + 1'b1;
      end
      fifoFillLevel <= next_level;
    end
  end

  // RULE9 threshold compare
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fifoIrq <= 1'b0;
    end else begin
      fifoIrq <= next_level > {1'b0, next_thr, 1'b0};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      modCfg[0]         <= `LSFW_CFG_RST;
      modCfg[1]         <= `LSFW_CFG_RST;
      fifoFillThreshold <= `LSFW_THR_RST;
    end else if (regWrEn) begin
      unique case (regAddr)
        `LSFW_ADDR_CFG0: modCfg[0] <= regWrData & `LSFW_CFG_WMASK;
        `LSFW_ADDR_CFG1: modCfg[1] <= regWrData & `LSFW_CFG_WMASK;
        `LSFW_ADDR_THR:  fifoFillThreshold <= regWrData;
        default: ;
      endcase
    end
  end

  // Empty FIFO reads as zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      unique case (regAddr)
        `LSFW_ADDR_CFG0:  regRdData <= modCfg[0];
        `LSFW_ADDR_CFG1:  regRdData <= modCfg[1];
        `LSFW_ADDR_THR:   regRdData <= fifoFillThreshold;
        `LSFW_ADDR_STAT0: regRdData <= fifoFillLevel[9:2];
        `LSFW_ADDR_STAT1: regRdData <= {6'h00, fifoFillLevel[1:0]};
        `LSFW_ADDR_DATA:  regRdData <= popOk ? mem[rdPtr] : 8'h00;
        default:          regRdData <= 8'h00;
      endcase
    end
  end

  sequence lightReq0_s;
    lightValid[0] && lightOk[0];
  endsequence

  // RULE1 result captured
  light_take_a: assert property (@(posedge clk_sys) // RULE1
    disable iff (!rst_n)
    lightReq0_s |=> lightPend[0] && lightBuf[0] == $past(lightResult[0]))
    else $error("enabled light result not captured");

  // RULE2 short light count
  light_block_a: assert property (@(posedge clk_sys) // RULE2
    disable iff (!rst_n)
    lightValid[0] && !lightPend[0] && flickerStepEn && !lightAfterFlicker &&
    lightSampleCount < flickerSampleCount |=> !lightPend[0])
    else $error("light result stored before flicker finished");

  // RULE3 modulator one gate
  light_off1_a: assert property (@(posedge clk_sys) // RULE3
    disable iff (!rst_n)
    lightValid[1] && !lightPend[1] && !modCfg[1].lightEn |=> !lightPend[1])
    else $error("modulator 1 light stored while disabled");

  // RULE8 level bound
  level_bound_a: assert property (@(posedge clk_sys) // RULE8
    disable iff (!rst_n)
    fifoFillLevel <= 10'(DEPTH) && !(full && push))
    else $error("fifo level beyond capacity");

  // RULE9 irq follows level
  irq_level_a: assert property (@(posedge clk_sys) // RULE9
    disable iff (!rst_n)
    ##1 fifoIrq == (fifoFillLevel > thrLevel))
    else $error("fifo interrupt disagrees with level");

endmodule

// ---- testbench/lsfw_host.sv ----
`timescale 1ns/1ps
module lsfw_host (
  input  wire logic       clk_sys,
  output logic      [7:0] regAddr,
  output logic            regWrEn,
  output logic      [7:0] regWrData,
  output logic            regRdEn,
  input  wire logic [7:0] regRdData
);
  initial begin
    regAddr   = 8'h00;
    regWrEn   = 1'h0;
    regWrData = 8'h00;
    regRdEn   = 1'h0;
  end

  // Write strobe stands for one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'h1;
    @(posedge clk_sys);
    regWrEn <= 1'h0;
  endtask

  // Read data stands until the next read, so it is taken one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'h1;
    @(posedge clk_sys);
    regRdEn <= 1'h0;
    @(posedge clk_sys);
    d = regRdData;
  endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`include "lsfw_cfg.svh"
module testbench;
  logic             clk_sys;
  logic             rst_n;
  logic [7:0]       regAddr;
  logic [7:0]       regWrData;
  logic [7:0]       regRdData;
  logic             regWrEn;
  logic             regRdEn;
  logic             flickerStepEn;
  logic             lightAfterFlicker;
  logic             measEnd;
  logic [15:0]      lightSampleCount;
  logic [15:0]      flickerSampleCount;
  logic [1:0]       lightValid;
  logic [1:0]       flickerValid;
  logic [1:0][15:0] lightResult;
  logic [1:0][15:0] flickerSample;
  logic [9:0]       fifoFillLevel;
  logic             fifoIrq;
  logic [7:0]       rdv;
  int               n_errors;
  int               n_tests;
  logic [7:0]       tCfg [3] = '{8'h03, 8'h07, 8'h0A};
  logic [15:0]      tVal [3] = '{16'hABCD, 16'hABCD, 16'hFFFF};
  logic [15:0]      tExp [3] = '{16'h000D, 16'h00CD, 16'h07FF};

  lsfw_top dut (.clk_sys, .rst_n, .regAddr, .regWrEn, .regWrData, .regRdEn,
    .regRdData, .flickerStepEn, .lightAfterFlicker, .lightSampleCount,
    .flickerSampleCount, .lightValid, .lightResult, .flickerValid,
    .flickerSample, .measEnd, .fifoFillLevel, .fifoIrq);
  lsfw_host host (.clk_sys, .regAddr, .regWrEn, .regWrData, .regRdEn,
    .regRdData);

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rdv);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdv});
  endtask

  task automatic pop16(input logic [15:0] e);
    reg_chk(`LSFW_ADDR_DATA, e[7:0]);
    reg_chk(`LSFW_ADDR_DATA, e[15:8]);
  endtask

  // Bounded wait; an exhausted bound ends the run
  task automatic wait_lvl(input logic [9:0] n);
    int i;
    for (i = 0; i < 40 && fifoFillLevel !== n; i++) @(posedge clk_sys);
    chk("fifoFillLevel", {6'h00, n}, {6'h00, fifoFillLevel});
    if (i == 40) wrap_up();
  endtask

  task automatic no_store();
    repeat (10) @(posedge clk_sys);
    chk("fifoFillLevel", 16'h0000, {6'h00, fifoFillLevel});
  endtask

  task automatic light(input int m, input logic [15:0] v);
    @(posedge clk_sys);
    lightResult[m] <= v;
    lightValid[m]  <= 1'h1;
    @(posedge clk_sys);
    lightValid <= 2'h0;
  endtask

  // Spacing keeps the packer from dropping samples
  task automatic flick(input int m, input logic [15:0] v);
    @(posedge clk_sys);
    flickerSample[m] <= v;
    flickerValid[m]  <= 1'h1;
    @(posedge clk_sys);
    flickerValid <= 2'h0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic end_meas();
    @(posedge clk_sys);
    measEnd <= 1'h1;
    @(posedge clk_sys);
    measEnd <= 1'h0;
  endtask

  initial begin
    rst_n = 1'h0;
    flickerStepEn = 1'h0;
    lightAfterFlicker = 1'h0;
    measEnd = 1'h0;
    lightSampleCount = 16'h0000;
    flickerSampleCount = 16'h0000;
    lightValid = 2'h0;
    flickerValid = 2'h0;
    lightResult = '0;
    flickerSample = '0;
    n_errors = 0;
    n_tests = 0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'h1;
    reg_chk(`LSFW_ADDR_CFG0, 8'h8F);
    reg_chk(`LSFW_ADDR_CFG1, 8'h8F);
    host.wr(`LSFW_ADDR_CFG0, 8'hFF);
    reg_chk(`LSFW_ADDR_CFG0, 8'hBF);
    reg_chk(8'h10, 8'h00);
    host.wr(`LSFW_ADDR_CFG0, 8'h8F);
    light(0, 16'h1234);
    wait_lvl(10'h002);
    reg_chk(`LSFW_ADDR_STAT0, 8'h00);
    reg_chk(`LSFW_ADDR_STAT1, 8'h02);
    host.wr(`LSFW_ADDR_THR, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("fifoIrq", 16'h0001, {15'h0000, fifoIrq});
    pop16(16'h1234);
    chk("fifoIrq", 16'h0000, {15'h0000, fifoIrq});
    @(posedge clk_sys);
    flickerStepEn <= 1'h1;
    lightSampleCount <= 16'h0002;
    flickerSampleCount <= 16'h0005;
    light(0, 16'h4321);
    no_store();
    lightAfterFlicker <= 1'h1;
    light(0, 16'hBEEF);
    wait_lvl(10'h002);
    pop16(16'hBEEF);
    lightAfterFlicker <= 1'h0;
    lightSampleCount <= 16'h0005;
    light(0, 16'h00A5);
    wait_lvl(10'h002);
    pop16(16'h00A5);
    flickerStepEn <= 1'h0;
    host.wr(`LSFW_ADDR_CFG1, 8'h0F);
    light(1, 16'h7777);
    no_store();
    host.wr(`LSFW_ADDR_CFG1, 8'h8F);
    light(1, 16'h5A6B);
    wait_lvl(10'h002);
    pop16(16'h5A6B);
    for (int k = 0; k < 3; k++) begin
      host.wr(`LSFW_ADDR_CFG0, tCfg[k]);
      flick(0, tVal[k]);
      wait_lvl(10'h002);
      pop16(tExp[k]);
    end
    end_meas();
    // Packs 5 then 9 in four bits, second case stores the delta 4
    for (int k = 0; k < 2; k++) begin
      host.wr(`LSFW_ADDR_CFG0, k ? 8'h33 : 8'h23);
      flick(0, 16'h0005);
      flick(0, 16'h0009);
      end_meas();
      wait_lvl(10'h001);
      reg_chk(`LSFW_ADDR_DATA, k ? 8'h45 : 8'h95);
    end
    // Three bits of 5 left partial; end of measurement pads the byte
    host.wr(`LSFW_ADDR_CFG0, 8'h22);
    flick(0, 16'h0005);
    end_meas();
    wait_lvl(10'h001);
    reg_chk(`LSFW_ADDR_DATA, 8'h05);
    wrap_up();
  end
endmodule
